// [dv/tb_return_and_rotate_carry_exec.sv]
// Self-checking bench for the return and rotate-through-carry block
`timescale 1ns/1ps
module tb_return_and_rotate_carry_exec
  import ret_rot_pkg::*;
;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [15:0] instr_in = 16'h0000;
  logic instr_valid_in = 1'b0;
  logic ext_set_en_in = 1'b0;
  logic [PC_WIDTH-1:0] stack_top_entry_in = '0;
  logic [7:0] working_shadow_in = 8'h00;
  logic [7:0] flags_shadow_in = 8'h00;
  logic [BANK_WIDTH-1:0] bank_select_shadow_in = '0;
  logic [BANK_WIDTH-1:0] bank_select_reg_in = '0;
  logic carry_in = 1'b0;
  logic [7:0] file_data_in = 8'h00;
  logic [1:0] phase_out;
  logic busy_out, pc_load_out, stack_pop_out, file_rd_out;
  logic [PC_WIDTH-1:0] pc_value_out;
  logic [7:0] flags_mask_out, file_addr_out;
  logic [BANK_WIDTH-1:0] file_bank_out;
  byte_write_type working_wr, flags_wr, file_wr;
  bank_write_type bank_wr;
  addr_mode_type addr_mode_out;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [15:0] corners [10] = '{16'h0012, 16'h0013, 16'h0010, 16'h0011,
    16'h3800, 16'h3400, 16'h36ff, 16'h345f, 16'h3460, 16'h3700};

  return_and_rotate_carry_exec return_and_rotate_carry_exec_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .instr_in(instr_in),
    .instr_valid_in(instr_valid_in), .ext_set_en_in(ext_set_en_in),
    .stack_top_entry_in(stack_top_entry_in),
    .working_shadow_in(working_shadow_in),
    .flags_shadow_in(flags_shadow_in),
    .bank_select_shadow_in(bank_select_shadow_in),
    .bank_select_reg_in(bank_select_reg_in), .carry_in(carry_in),
    .file_data_in(file_data_in), .phase_out(phase_out),
    .busy_out(busy_out), .pc_load_out(pc_load_out),
    .pc_value_out(pc_value_out), .stack_pop_out(stack_pop_out),
    .working_wr_out(working_wr), .flags_wr_out(flags_wr),
    .flags_mask_out(flags_mask_out), .bank_select_wr_out(bank_wr),
    .file_rd_out(file_rd_out), .file_addr_out(file_addr_out),
    .file_bank_out(file_bank_out), .addr_mode_out(addr_mode_out),
    .file_wr_out(file_wr));

  always #50 clk_in = ~clk_in;

  task automatic stop_test;
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  // Run length is a few thousand cycles, so this only trips on a hang
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [20:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic addr_mode_type exp_mode(input logic [15:0] w,
                                             input logic ext);
    if (w[8]) return ADDR_BANKED;
    if (ext && w[7:0] <= 8'h5f) return ADDR_INDEXED;
    return ADDR_ACCESS;
  endfunction : exp_mode

  task automatic run(input logic [15:0] w);
    logic [7:0] d, res, ws, fs;
    logic [20:0] st;
    logic [3:0] bs, br;
    logic c, ext, ret, rot, s;
    int n;
    ret = (w[15:1] == 15'h0009);
    rot = (w[15:10] == 6'h0d);
    s = ret & w[0];
    d = 8'($urandom); ws = 8'($urandom); fs = 8'($urandom);
    st = 21'($urandom); bs = 4'($urandom); br = 4'($urandom);
    c = 1'($urandom); ext = 1'($urandom);
    // Launch so the word is stable across the next Q1 edge
    @(posedge clk_in);
    while (phase_out !== 2'h3) @(posedge clk_in);
    instr_in <= w; instr_valid_in <= 1'b1; file_data_in <= d;
    carry_in <= c; ext_set_en_in <= ext; stack_top_entry_in <= st;
    working_shadow_in <= ws; flags_shadow_in <= fs;
    bank_select_shadow_in <= bs; bank_select_reg_in <= br;
    @(posedge clk_in);
    // A return keeps a rotate on offer into its idle cycle, which must drop it
    instr_valid_in <= ret;
    if (ret) instr_in <= 16'h3600;
    @(negedge clk_in);
    chk("phase", 21'(PHASE_Q2), 21'(phase_out));
    chk("file_rd", 21'(rot), 21'(file_rd_out));
    if (rot) begin
      chk("addr", 21'(w[7:0]), 21'(file_addr_out));
      chk("mode", 21'(exp_mode(w, ext)), 21'(addr_mode_out));
      if (w[8]) chk("bank", 21'(br), 21'(file_bank_out));
    end
    // Write strobes stand between the Q4 edge and the next Q1 edge
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    res = {d[6:0], c};
    chk("pc_load", 21'(ret), 21'(pc_load_out));
    chk("pop", 21'(ret), 21'(stack_pop_out));
    if (ret) chk("pc", st, pc_value_out);
    chk("w_en", 21'(s | (rot & ~w[9])), 21'(working_wr.en));
    chk("f_en", 21'(rot & w[9]), 21'(file_wr.en));
    chk("fl_en", 21'(s | rot), 21'(flags_wr.en));
    chk("b_en", 21'(s), 21'(bank_wr.en));
    if (s) begin
      chk("w_val", 21'(ws), 21'(working_wr.value));
      chk("fl_val", 21'(fs), 21'(flags_wr.value));
      chk("fl_mask", 21'hff, 21'(flags_mask_out));
      chk("b_val", 21'(bs), 21'(bank_wr.value));
    end
    if (rot) begin
      chk("res", 21'(res),
          21'(w[9] ? file_wr.value : working_wr.value));
      chk("fl_mask", 21'h15, 21'(flags_mask_out));
      chk("fl_val",
          21'({res[7], 1'b0, res == 8'h00, 1'b0, d[7]}),
          21'(flags_wr.value[4:0]));
    end
    @(negedge clk_in);
    chk("strobes", 21'h0,
        21'({pc_load_out, working_wr.en, flags_wr.en, file_wr.en,
        bank_wr.en, file_rd_out}));
    if (ret) begin
      @(posedge clk_in);
      instr_valid_in <= 1'b0;
      @(negedge clk_in);
      chk("busy", 21'h1, 21'(busy_out));
      n = 0;
      while (busy_out !== 1'b0 && n < 20) begin
        @(negedge clk_in);
        n++;
      end
      chk("busy_len", 21'd3, 21'(n));
    end
  endtask : run

  initial begin
    logic [15:0] w;
    void'($urandom(14));
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    // Corner words: both returns, rotates at the indexed limit, and inert neighbours of each
    foreach (corners[i])
      run(corners[i]);
    repeat (200) begin
      case ($urandom % 3)
        0: w = {6'h0d, 10'($urandom)};
        1: w = {15'h0009, 1'($urandom)};
        default: w = 16'($urandom);
      endcase
      run(w);
    end
    stop_test();
  end
endmodule : tb_return_and_rotate_carry_exec

// [logic/ret_rot_pkg.sv]
// Constants and types for the return and rotate-through-carry execution block
package ret_rot_pkg;
  localparam int PC_WIDTH = 21;
  localparam int BANK_WIDTH = 4;
  localparam logic [15:0] RET_PATTERN = 16'h0012;
  localparam logic [15:0] RET_MASK = 16'hfffe;
  localparam logic [15:0] ROT_PATTERN = 16'h3400;
  localparam logic [15:0] ROT_MASK = 16'hfc00;
  localparam int RESTORE_POS = 0;
  localparam int DEST_POS = 9;
  localparam int BANK_POS = 8;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  localparam int CARRY_POS = 0;
  localparam int ZERO_POS = 2;
  localparam int NEG_POS = 4;
  localparam logic [7:0] ROT_FLAG_MASK = 8'h15;
  localparam logic [7:0] ALL_FLAG_MASK = 8'hff;
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q3 = 2'h2;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] INSTR_RESET = 16'h0000;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_RET = 2'b01,
    OP_RET_NOP = 2'b10,
    OP_ROT = 2'b11
  } op_type;

  typedef enum logic [1:0] {
    ADDR_ACCESS = 2'b00,
    ADDR_BANKED = 2'b01,
    ADDR_INDEXED = 2'b10
  } addr_mode_type;

  typedef struct packed {
    logic en;
    logic [7:0] value;
  } byte_write_type;

  typedef struct packed {
    logic en;
    logic [BANK_WIDTH-1:0] value;
  } bank_write_type;
endpackage : ret_rot_pkg

// [logic/return_and_rotate_carry_exec.sv]
// Execution of return-from-subroutine and rotate-left-through-carry
`timescale 1ns/1ps
// Overview of operation
// - A return pops the stack and loads the stack top entry into the PC, leaving both PC latches alone.
// - A return with restore bit 1 copies the three shadow registers into working, flags and bank select.
// - A return with restore bit 0 touches neither working, flags nor bank select, and changes no flag.
// - The return is decoded as the word 0000 0000 0001 001 plus the restore bit at bit 0.
// - The return takes two cycles, popping into the PC in phase four of the first and idling in the second.
// - The rotate (prefix 0011 01) shifts the operand left, bit 7 to carry and old carry to bit 0.
// - Rotate destination bit 0 writes the working register, 1 writes the operand file register.
// - Rotate bank bit 0 addresses the access bank, 1 uses the bank select register.
// - With the extended set on, bank bit 0 and address up to 95 the rotate uses indexed literal offset.
module return_and_rotate_carry_exec
  import ret_rot_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [15:0] instr_in,
  input wire logic instr_valid_in,
  input wire logic ext_set_en_in,
  input wire logic [PC_WIDTH-1:0] stack_top_entry_in,
  input wire logic [7:0] working_shadow_in,
  input wire logic [7:0] flags_shadow_in,
  input wire logic [BANK_WIDTH-1:0] bank_select_shadow_in,
  input wire logic [BANK_WIDTH-1:0] bank_select_reg_in,
  input wire logic carry_in,
  input wire logic [7:0] file_data_in,
  output logic [1:0] phase_out,
  output logic busy_out,
  output logic pc_load_out,
  output logic [PC_WIDTH-1:0] pc_value_out,
  output logic stack_pop_out,
  output byte_write_type working_wr_out,
  output byte_write_type flags_wr_out,
  output logic [7:0] flags_mask_out,
  output bank_write_type bank_select_wr_out,
  output logic file_rd_out,
  output logic [7:0] file_addr_out,
  output logic [BANK_WIDTH-1:0] file_bank_out,
  output addr_mode_type addr_mode_out,
  output byte_write_type file_wr_out
);

  function automatic addr_mode_type pick_mode(input logic bank_bit,
                                              input logic ext_on,
                                              input logic [7:0] addr);
    if (bank_bit) begin
      return ADDR_BANKED;
    end
    if (ext_on && (addr <= INDEXED_LIMIT)) begin
      return ADDR_INDEXED;
    end
    return ADDR_ACCESS;
  endfunction : pick_mode

  op_type op;
  op_type next_op;
  logic [15:0] instr;
  logic [7:0] operand;
  logic carry_saved;
  logic [7:0] result;

  wire logic at_q1 = (phase_out == PHASE_Q1);
  wire logic at_q2 = (phase_out == PHASE_Q2);
  wire logic at_q3 = (phase_out == PHASE_Q3);
  wire logic at_q4 = (phase_out == PHASE_Q4);
  wire logic is_ret = ((instr_in & RET_MASK) == RET_PATTERN);
  wire logic is_rot = ((instr_in & ROT_MASK) == ROT_PATTERN);
  wire logic restore = instr[RESTORE_POS];
  wire logic dest_file = instr[DEST_POS];
  wire logic [7:0] rot_value = {operand[6:0], carry_in};
  wire addr_mode_type next_mode =
    pick_mode(instr_in[BANK_POS], ext_set_en_in, instr_in[7:0]);

  // A return swallows the next slot, so the word offered then is dropped
  assign next_op = (op == OP_RET) ? OP_RET_NOP :
                   !instr_valid_in ? OP_NONE :
                   is_ret ? OP_RET :
                   is_rot ? OP_ROT : OP_NONE;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_out <= PHASE_Q1;
    end else begin
      phase_out <= phase_out + 2'h1;
    end
  end

  // Decode during Q1
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op <= OP_NONE;
      busy_out <= 1'b0;
      instr <= INSTR_RESET;
      file_addr_out <= BYTE_RESET;
      file_bank_out <= '0;
      addr_mode_out <= ADDR_ACCESS;
    end else if (at_q1) begin
      op <= next_op;
      busy_out <= (op == OP_RET);
      if (op != OP_RET) begin
        instr <= instr_in;
        file_addr_out <= instr_in[7:0];
        file_bank_out <= bank_select_reg_in;
        addr_mode_out <= next_mode;
      end
    end
  end

  // Operand read in Q2, processing in Q3
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      file_rd_out <= 1'b0;
      operand <= BYTE_RESET;
      carry_saved <= 1'b0;
      result <= BYTE_RESET;
    end else begin
      file_rd_out <= at_q1 && (next_op == OP_ROT);
      if (at_q2 && op == OP_ROT) begin
        operand <= file_data_in;
      end
      // Result settles on the Q3 edge so the Q4 write carries this carry
      if (at_q3 && op == OP_ROT) begin
        carry_saved <= carry_in;
        result <= rot_value;
      end
    end
  end

  // Write-back strobes leave on the Q4 edge and stand for one clock
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pc_load_out <= 1'b0;
      pc_value_out <= '0;
      stack_pop_out <= 1'b0;
      working_wr_out <= '0;
      flags_wr_out <= '0;
      flags_mask_out <= BYTE_RESET;
      bank_select_wr_out <= '0;
      file_wr_out <= '0;
    end else begin
      pc_load_out <= at_q4 && op == OP_RET;
      stack_pop_out <= at_q4 && op == OP_RET;
      if (at_q4 && op == OP_RET) begin
        pc_value_out <= stack_top_entry_in;
      end
      working_wr_out.en <= at_q4 && ((op == OP_RET && restore) ||
                           (op == OP_ROT && !dest_file));
      working_wr_out.value <= (op == OP_RET) ? working_shadow_in : result;
      file_wr_out.en <= at_q4 && op == OP_ROT && dest_file;
      file_wr_out.value <= result;
      bank_select_wr_out.en <= at_q4 && op == OP_RET && restore;
      bank_select_wr_out.value <= bank_select_shadow_in;
      flags_wr_out.en <= at_q4 && ((op == OP_RET && restore) ||
                         op == OP_ROT);
      if (op == OP_RET) begin
        flags_wr_out.value <= flags_shadow_in;
        flags_mask_out <= ALL_FLAG_MASK;
      end else begin
        flags_wr_out.value <= BYTE_RESET;
        flags_wr_out.value[CARRY_POS] <= operand[7];
        flags_wr_out.value[ZERO_POS] <= (result == BYTE_RESET);
        flags_wr_out.value[NEG_POS] <= result[7];
        flags_mask_out <= ROT_FLAG_MASK;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  ret_pop_pc_a: assert property (
    (op == OP_RET && at_q4) |=> (pc_load_out && stack_pop_out &&
      pc_value_out == $past(stack_top_entry_in)))
    else $error("return did not load the stack top into the PC");

  ret_restore_a: assert property (
    (op == OP_RET && at_q4 && restore) |=> (working_wr_out.en &&
      working_wr_out.value == $past(working_shadow_in) &&
      flags_wr_out.value == $past(flags_shadow_in) &&
      bank_select_wr_out.en &&
      bank_select_wr_out.value == $past(bank_select_shadow_in)))
    else $error("shadow restore missing or wrong");

  ret_no_restore_a: assert property (
    (op == OP_RET && !restore) |=> (!working_wr_out.en &&
      !flags_wr_out.en && !bank_select_wr_out.en))
    else $error("return without restore changed a register");

  ret_decode_a: assert property (
    (at_q1 && op != OP_RET && instr_valid_in &&
     instr_in[15:1] == 15'h0009) |=> (op == OP_RET))
    else $error("return word not recognised");

  ret_two_cycle_a: assert property (
    pc_load_out |=> (busy_out && !pc_load_out && !file_rd_out &&
      !file_wr_out.en && !working_wr_out.en)[*4] ##1 !busy_out)
    else $error("second return cycle was not idle");

  rot_result_a: assert property (
    (op == OP_ROT && at_q4) |=> (flags_wr_out.value[CARRY_POS] ==
      $past(operand[7]) && (file_wr_out.en ? file_wr_out.value :
      working_wr_out.value) == {$past(operand[6:0]), $past(carry_saved)}))
    else $error("rotate result or carry wrong");

  rot_dest_a: assert property (
    (op == OP_ROT && at_q4) |=>
      (file_wr_out.en == $past(dest_file) &&
       working_wr_out.en == !$past(dest_file)))
    else $error("rotate wrote the wrong destination");

  rot_addr_mode_a: assert property (
    (at_q1 && next_op == OP_ROT) |=> (addr_mode_out ==
      ($past(instr_in[BANK_POS]) ? ADDR_BANKED :
       ($past(ext_set_en_in) && $past(instr_in[7:0]) <= 8'h5f) ?
       ADDR_INDEXED : ADDR_ACCESS)))
    else $error("rotate addressing mode wrong");

  rot_one_cycle_a: assert property (
    (at_q1 && next_op == OP_ROT) |=> file_rd_out ##3 (flags_wr_out.en &&
      flags_mask_out == ROT_FLAG_MASK &&
      flags_wr_out.value[ZERO_POS] == (result == 8'h00) &&
      flags_wr_out.value[NEG_POS] == result[7]))
    else $error("rotate timing or N/Z flags wrong");

endmodule : return_and_rotate_carry_exec
